// ---- design/gpio_port_cfg.sv ----
`timescale 1ns/100ps
module gpio_port_cfg #(
   parameter int unsigned PORT_INDEX = 0,
   parameter logic [7:0] PIN_MASK = 8'hFF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic module_clk_en,
   input wire logic [7:0] pad_in,
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe_n,
   output logic [7:0] pad_pull_up,
   output logic [7:0] pad_pull_down,
   output logic [7:0] pad_digital_en,
   output logic [7:0] pad_drive_2ma,
   output logic [7:0] pad_drive_4ma,
   output logic [7:0] pad_drive_8ma,
   output logic [7:0] pad_slew_limit,
   input wire logic [7:0] alt_out,
   input wire logic [7:0] alt_oe,
   output logic [7:0] alt_in
);
   // debug pins of this instance
   localparam logic [7:0] PROT = (PORT_INDEX == gpio_cfg_pkg::PORT_B) ?
      gpio_cfg_pkg::DBG_PINS_B : (PORT_INDEX == gpio_cfg_pkg::PORT_C) ?
      gpio_cfg_pkg::DBG_PINS_C : gpio_cfg_pkg::RST_ZERO;
   // debug pins come up in debug function, everything else zero; commit bits come up set except on debug pins
   localparam logic [7:0] RST_DBG_ON = gpio_cfg_pkg::RST_ZERO | PROT;
   localparam logic [7:0] RST_COMMIT = gpio_cfg_pkg::RST_COMMIT_ALL & ~PROT;

   cfg_bus_if bus ();

   logic port_ready;
   logic wr;
   logic [7:0] wd;
   logic [7:0] read_val;
   logic [7:0] alt_wmask;

   logic [1:0] settle_ff;
   logic [1:0] nxt_settle;
   logic [7:0] sync1_ff;
   logic [7:0] sync2_ff;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic err_ff;
   logic nxt_err;

   logic [7:0] data_ff, nxt_data;
   logic [7:0] dir_ff, nxt_dir;
   logic [7:0] sense_ff, nxt_sense;
   logic [7:0] both_ff, nxt_both;
   logic [7:0] event_ff, nxt_event;
   logic [7:0] mask_ff, nxt_mask;
   logic [7:0] alt_sel_ff, nxt_alt_sel;
   logic [7:0] drv2_ff, nxt_drv2;
   logic [7:0] drv4_ff, nxt_drv4;
   logic [7:0] drv8_ff, nxt_drv8;
   logic [7:0] odr_ff, nxt_odr;
   logic [7:0] pull_up_ff, nxt_pull_up;
   logic [7:0] pull_down_ff, nxt_pull_down;
   logic [7:0] slew_ff, nxt_slew;
   logic [7:0] den_ff, nxt_den;
   logic [7:0] commit_ff, nxt_commit;
   logic unlocked_ff, nxt_unlocked;

   // masked field update; bits outside wmask keep their value
   function automatic logic [7:0] upd(input logic [7:0] cur, input logic hit,
      input logic [7:0] val, input logic [7:0] wmask);
      upd = hit ? ((cur & ~wmask) | (val & wmask)) : cur;
   endfunction : upd

   apb_port_decode #(
      .PORT_INDEX(PORT_INDEX)
   ) u_decode (
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .port_ready(port_ready),
      .bus(bus)
   );

   // clock gate settle counter and pad synchroniser
   always_comb
   begin
      if (!module_clk_en)
      begin
         nxt_settle = 2'h0;
      end
      else if (settle_ff != gpio_cfg_pkg::CLK_SETTLE_CYCLES)
      begin
         nxt_settle = settle_ff + 2'h1;
      end
      else
      begin
         nxt_settle = settle_ff;
      end
   end

   // a gated-off or still settling port refuses accesses with an error
   assign port_ready = module_clk_en &&
      (settle_ff == gpio_cfg_pkg::CLK_SETTLE_CYCLES);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         settle_ff <= 2'h0;
         sync1_ff <= 8'h00;
         sync2_ff <= 8'h00;
      end
      else
      begin
         settle_ff <= nxt_settle;
         sync1_ff <= pad_in;
         sync2_ff <= sync1_ff;
      end
   end

   // read mux; pad-less positions forced to zero except in the unlock register
   always_comb
   begin
      read_val = 8'h00;
      if (bus.off <= gpio_cfg_pkg::OFF_DATA_TOP)
      begin
         read_val = data_ff & bus.off[9:2]; // address bits select data bits
      end
      else
      begin
         case (bus.off)
            gpio_cfg_pkg::OFF_DIR: read_val = dir_ff;
            gpio_cfg_pkg::OFF_IRQ_SENSE: read_val = sense_ff;
            gpio_cfg_pkg::OFF_IRQ_BOTH: read_val = both_ff;
            gpio_cfg_pkg::OFF_IRQ_EVENT: read_val = event_ff;
            gpio_cfg_pkg::OFF_IRQ_MASK: read_val = mask_ff;
            gpio_cfg_pkg::OFF_ALT_SEL: read_val = alt_sel_ff;
            gpio_cfg_pkg::OFF_DRV2: read_val = drv2_ff;
            gpio_cfg_pkg::OFF_DRV4: read_val = drv4_ff;
            gpio_cfg_pkg::OFF_DRV8: read_val = drv8_ff;
            gpio_cfg_pkg::OFF_OPEN_DRAIN: read_val = odr_ff;
            gpio_cfg_pkg::OFF_PULL_UP: read_val = pull_up_ff;
            gpio_cfg_pkg::OFF_PULL_DOWN: read_val = pull_down_ff;
            gpio_cfg_pkg::OFF_SLEW: read_val = slew_ff;
            gpio_cfg_pkg::OFF_DIG_EN: read_val = den_ff;
            gpio_cfg_pkg::OFF_UNLOCK: read_val = {7'h00, ~unlocked_ff};
            gpio_cfg_pkg::OFF_COMMIT: read_val = commit_ff;
            default: read_val = 8'h00;
         endcase
      end
      if (bus.off != gpio_cfg_pkg::OFF_UNLOCK)
      begin
         read_val = read_val & PIN_MASK;
      end
   end

   // answer is prepared in the setup cycle so prdata comes from a flip-flop
   always_comb
   begin
      nxt_prdata = prdata_ff;
      nxt_err = err_ff;
      if (bus.setup)
      begin
         nxt_err = ~bus.ok;
         nxt_prdata = (bus.ok && !bus.write) ? {24'h000000, read_val} : 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff <= 32'h00000000;
         err_ff <= 1'b0;
      end
      else
      begin
         prdata_ff <= nxt_prdata;
         err_ff <= nxt_err;
      end
   end

   // zero wait states: the access phase always ends in its first cycle
   assign pready = 1'b1;
   assign pslverr = bus.access & err_ff;
   assign prdata = prdata_ff;

   // write strobe, only for an accepted write in the access phase
   assign wr = bus.access & bus.write & ~err_ff;
   assign wd = bus.wdata[7:0];
   // protected bits need the unlock and their commit bit
   assign alt_wmask = PIN_MASK & (~PROT | (commit_ff & {8{unlocked_ff}}));

   // next values of the configuration registers
   always_comb
   begin
      // input pins follow the pad, output pins keep what software wrote
      nxt_data = (data_ff & dir_ff) | (sync2_ff & ~dir_ff & PIN_MASK);
      nxt_data = upd(nxt_data, wr && (bus.off <= gpio_cfg_pkg::OFF_DATA_TOP),
         wd, PIN_MASK & dir_ff & bus.off[9:2]);
      nxt_dir = upd(dir_ff, wr && bus.off == gpio_cfg_pkg::OFF_DIR, wd, PIN_MASK);
      // interrupt setup is only stored here and read back over the bus
      nxt_sense = upd(sense_ff, wr && bus.off == gpio_cfg_pkg::OFF_IRQ_SENSE, wd,
         PIN_MASK);
      nxt_both = upd(both_ff, wr && bus.off == gpio_cfg_pkg::OFF_IRQ_BOTH, wd,
         PIN_MASK);
      nxt_event = upd(event_ff, wr && bus.off == gpio_cfg_pkg::OFF_IRQ_EVENT, wd,
         PIN_MASK);
      nxt_mask = upd(mask_ff, wr && bus.off == gpio_cfg_pkg::OFF_IRQ_MASK, wd,
         PIN_MASK);
      nxt_alt_sel = upd(alt_sel_ff, wr && bus.off == gpio_cfg_pkg::OFF_ALT_SEL, wd,
         alt_wmask);
      nxt_drv2 = upd(drv2_ff, wr && bus.off == gpio_cfg_pkg::OFF_DRV2, wd, PIN_MASK);
      nxt_drv4 = upd(drv4_ff, wr && bus.off == gpio_cfg_pkg::OFF_DRV4, wd, PIN_MASK);
      nxt_drv8 = upd(drv8_ff, wr && bus.off == gpio_cfg_pkg::OFF_DRV8, wd, PIN_MASK);
      nxt_odr = upd(odr_ff, wr && bus.off == gpio_cfg_pkg::OFF_OPEN_DRAIN, wd,
         PIN_MASK);
      nxt_pull_up = upd(pull_up_ff, wr && bus.off == gpio_cfg_pkg::OFF_PULL_UP, wd,
         PIN_MASK);
      nxt_pull_down = upd(pull_down_ff, wr && bus.off == gpio_cfg_pkg::OFF_PULL_DOWN,
         wd, PIN_MASK);
      nxt_slew = upd(slew_ff, wr && bus.off == gpio_cfg_pkg::OFF_SLEW, wd, PIN_MASK);
      nxt_den = upd(den_ff, wr && bus.off == gpio_cfg_pkg::OFF_DIG_EN, wd, PIN_MASK);
      // only the debug positions are writable, and only while unlocked
      nxt_commit = upd(commit_ff, wr && bus.off == gpio_cfg_pkg::OFF_COMMIT, wd,
         PROT & PIN_MASK & {8{unlocked_ff}});
      // any write of another value to the unlock register locks again; writes elsewhere keep the state
      nxt_unlocked = unlocked_ff;
      if (wr && bus.off == gpio_cfg_pkg::OFF_UNLOCK)
      begin
         nxt_unlocked = (bus.wdata == gpio_cfg_pkg::UNLOCK_KEY);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         data_ff <= gpio_cfg_pkg::RST_ZERO;
         dir_ff <= gpio_cfg_pkg::RST_ZERO;
         sense_ff <= gpio_cfg_pkg::RST_ZERO;
         both_ff <= gpio_cfg_pkg::RST_ZERO;
         event_ff <= gpio_cfg_pkg::RST_ZERO;
         mask_ff <= gpio_cfg_pkg::RST_ZERO;
         alt_sel_ff <= RST_DBG_ON;
         drv2_ff <= gpio_cfg_pkg::RST_ZERO;
         drv4_ff <= gpio_cfg_pkg::RST_ZERO;
         drv8_ff <= gpio_cfg_pkg::RST_ZERO;
         odr_ff <= gpio_cfg_pkg::RST_ZERO;
         pull_up_ff <= RST_DBG_ON;
         pull_down_ff <= gpio_cfg_pkg::RST_ZERO;
         slew_ff <= gpio_cfg_pkg::RST_ZERO;
         den_ff <= RST_DBG_ON;
         commit_ff <= RST_COMMIT;
         unlocked_ff <= 1'b0;
      end
      else
      begin
         data_ff <= nxt_data;
         dir_ff <= nxt_dir;
         sense_ff <= nxt_sense;
         both_ff <= nxt_both;
         event_ff <= nxt_event;
         mask_ff <= nxt_mask;
         alt_sel_ff <= nxt_alt_sel;
         drv2_ff <= nxt_drv2;
         drv4_ff <= nxt_drv4;
         drv8_ff <= nxt_drv8;
         odr_ff <= nxt_odr;
         pull_up_ff <= nxt_pull_up;
         pull_down_ff <= nxt_pull_down;
         slew_ff <= nxt_slew;
         den_ff <= nxt_den;
         commit_ff <= nxt_commit;
         unlocked_ff <= nxt_unlocked;
      end
   end

   // static pad settings go straight out of their registers
   assign pad_pull_up = pull_up_ff;
   assign pad_pull_down = pull_down_ff;
   assign pad_digital_en = den_ff;
   assign pad_drive_2ma = drv2_ff;
   assign pad_drive_4ma = drv4_ff;
   assign pad_drive_8ma = drv8_ff;
   assign pad_slew_limit = slew_ff;

   pad_drive_mux #(
      .PINS(gpio_cfg_pkg::PINS)
   ) u_pads (
      .pclk(pclk),
      .presetn(presetn),
      .alt_sel(alt_sel_ff),
      .dir(dir_ff),
      .open_drain(odr_ff),
      .dig_en(den_ff),
      .data(data_ff),
      .alt_out(alt_out),
      .alt_oe(alt_oe),
      .pad_sync(sync2_ff),
      .pad_out(pad_out),
      .pad_oe_n(pad_oe_n),
      .alt_in(alt_in)
   );

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_gate_opens;
      $rose(module_clk_en) ##1 module_clk_en [*3];
   endsequence
   sequence s_refused_setup;
      psel && !penable && !port_ready;
   endsequence

   a_reset_dbg_func: assert property ($rose(presetn) |->
      alt_sel_ff == RST_DBG_ON && den_ff == RST_DBG_ON && pull_up_ff == RST_DBG_ON)
      else $error("debug pins not in debug function after reset");
   a_reset_commit: assert property ($rose(presetn) |-> commit_ff == RST_COMMIT)
      else $error("commit control reset value wrong");
   a_reset_undriven: assert property ($rose(presetn) |->
      pull_down_ff == 8'h00 && ((alt_sel_ff | den_ff | pull_up_ff) & ~PROT) == 8'h00)
      else $error("non-debug pins not cleared after reset");
   a_commit_readonly: assert property (((commit_ff ^ $past(commit_ff)) & ~PROT) == 8'h00)
      else $error("read-only commit bit changed");
   a_alt_protected: assert property ($past(!unlocked_ff) |->
      ((alt_sel_ff ^ $past(alt_sel_ff)) & PROT) == 8'h00)
      else $error("protected alternate bit changed while locked");
   a_padless_write: assert property ($stable(dir_ff & ~PIN_MASK) &&
      $stable(alt_sel_ff & ~PIN_MASK & ~PROT))
      else $error("write reached a pad-less position");
   a_padless_read: assert property (pslverr || !(psel && penable) ||
      (prdata[7:0] & ~PIN_MASK) == 8'h00 || bus.off == gpio_cfg_pkg::OFF_UNLOCK)
      else $error("pad-less position read as nonzero");
   a_input_capture: assert property ($past(dir_ff) == 8'h00 && !$past(wr) |->
      data_ff == ($past(sync2_ff) & PIN_MASK))
      else $error("input pin not captured into data");
   a_output_drive: assert property (1'b1 ##1 1'b1 |->
      ((pad_oe_n | (pad_out ^ $past(data_ff))) &
      $past(dir_ff & ~alt_sel_ff & den_ff & ~odr_ff)) == 8'h00)
      else $error("output pin not driving its data bit");
   a_settle_wait: assert property (s_gate_opens |-> port_ready && $past(!port_ready))
      else $error("port ready at the wrong cycle after clock enable");
   a_refuse_early: assert property (s_refused_setup ##1 (psel && penable) |-> pslverr)
      else $error("access before settle not refused");
endmodule : gpio_port_cfg

// ---- include/gpio_cfg_pkg.sv ----
package gpio_cfg_pkg;
   // pin positions per port instance
   localparam int unsigned PINS = 8;
   // register offsets inside one port window
   localparam logic [11:0] OFF_DATA_TOP = 12'h3FC;
   localparam logic [11:0] OFF_DIR = 12'h400;
   localparam logic [11:0] OFF_IRQ_SENSE = 12'h404;
   localparam logic [11:0] OFF_IRQ_BOTH = 12'h408;
   localparam logic [11:0] OFF_IRQ_EVENT = 12'h40C;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h410;
   localparam logic [11:0] OFF_ALT_SEL = 12'h420;
   localparam logic [11:0] OFF_DRV2 = 12'h500;
   localparam logic [11:0] OFF_DRV4 = 12'h504;
   localparam logic [11:0] OFF_DRV8 = 12'h508;
   localparam logic [11:0] OFF_OPEN_DRAIN = 12'h50C;
   localparam logic [11:0] OFF_PULL_UP = 12'h510;
   localparam logic [11:0] OFF_PULL_DOWN = 12'h514;
   localparam logic [11:0] OFF_SLEW = 12'h518;
   localparam logic [11:0] OFF_DIG_EN = 12'h51C;
   localparam logic [11:0] OFF_UNLOCK = 12'h520;
   localparam logic [11:0] OFF_COMMIT = 12'h524;
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_COMMIT_ALL = 8'hFF;
   localparam logic [7:0] DBG_PINS_B = 8'h80;
   localparam logic [7:0] DBG_PINS_C = 8'h0F;
   localparam int unsigned PORT_B = 1;
   localparam int unsigned PORT_C = 2;
   // port base addresses, four low ports then four high ports
   localparam logic [31:0] BASE_LOW = 32'h40004000;
   localparam logic [31:0] BASE_HIGH = 32'h40024000;
   localparam logic [31:0] BASE_STEP = 32'h00001000;
   // cycles from module clock enable to first legal access
   localparam logic [1:0] CLK_SETTLE_CYCLES = 2'h3;
   // arbitrary unlock key value
   localparam logic [31:0] UNLOCK_KEY = 32'h600DC0DE;

   function automatic logic [31:0] port_base(input int unsigned idx);
      if (idx < 4)
      begin
         port_base = BASE_LOW + 32'(idx) * BASE_STEP;
      end
      else
      begin
         port_base = BASE_HIGH + 32'(idx - 4) * BASE_STEP;
      end
   endfunction : port_base
endpackage : gpio_cfg_pkg

// ---- include/cfg_bus_if.sv ----
`timescale 1ns/100ps
// decoded register access between the address decoder and the register file
interface cfg_bus_if;
   logic setup;
   logic access;
   logic write;
   logic ok;
   logic [11:0] off;
   logic [31:0] wdata;
   modport dec (output setup, output access, output write, output ok, output off,
      output wdata);
   modport core (input setup, input access, input write, input ok, input off,
      input wdata);
endinterface : cfg_bus_if

// ---- design/apb_port_decode.sv ----
`timescale 1ns/100ps
module apb_port_decode #(
   parameter int unsigned PORT_INDEX = 0
) (
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic port_ready,
   cfg_bus_if.dec bus
);
   localparam logic [31:0] BASE = gpio_cfg_pkg::port_base(PORT_INDEX);

   logic base_hit;
   logic known;

   // the offset is added to this port's base; only the page number is compared
   assign base_hit = (paddr[31:12] == BASE[31:12]);
   assign known = (paddr[1:0] == 2'h0) &&
      ((paddr[11:0] <= gpio_cfg_pkg::OFF_DATA_TOP) ||
      (paddr[11:0] inside {gpio_cfg_pkg::OFF_DIR, gpio_cfg_pkg::OFF_IRQ_SENSE,
      gpio_cfg_pkg::OFF_IRQ_BOTH, gpio_cfg_pkg::OFF_IRQ_EVENT,
      gpio_cfg_pkg::OFF_IRQ_MASK, gpio_cfg_pkg::OFF_ALT_SEL,
      gpio_cfg_pkg::OFF_DRV2, gpio_cfg_pkg::OFF_DRV4, gpio_cfg_pkg::OFF_DRV8,
      gpio_cfg_pkg::OFF_OPEN_DRAIN, gpio_cfg_pkg::OFF_PULL_UP,
      gpio_cfg_pkg::OFF_PULL_DOWN, gpio_cfg_pkg::OFF_SLEW,
      gpio_cfg_pkg::OFF_DIG_EN, gpio_cfg_pkg::OFF_UNLOCK,
      gpio_cfg_pkg::OFF_COMMIT}));

   // phase strobes and the verdict on the address and port readiness
   assign bus.setup = psel & ~penable;
   assign bus.access = psel & penable;
   assign bus.write = pwrite;
   assign bus.ok = base_hit & known & port_ready;
   assign bus.off = paddr[11:0];
   assign bus.wdata = pwdata;
endmodule : apb_port_decode

// ---- design/pad_drive_mux.sv ----
`timescale 1ns/100ps
module pad_drive_mux #(
   parameter int unsigned PINS = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [PINS-1:0] alt_sel,
   input wire logic [PINS-1:0] dir,
   input wire logic [PINS-1:0] open_drain,
   input wire logic [PINS-1:0] dig_en,
   input wire logic [PINS-1:0] data,
   input wire logic [PINS-1:0] alt_out,
   input wire logic [PINS-1:0] alt_oe,
   input wire logic [PINS-1:0] pad_sync,
   output logic [PINS-1:0] pad_out,
   output logic [PINS-1:0] pad_oe_n,
   output logic [PINS-1:0] alt_in
);
   logic [PINS-1:0] nxt_out;
   logic [PINS-1:0] nxt_oe_n;
   logic [PINS-1:0] nxt_alt_in;
   logic [PINS-1:0] out_ff;
   logic [PINS-1:0] oe_n_ff;
   logic [PINS-1:0] alt_in_ff;

   // every pin position gets the same pad logic
   for (genvar i = 0; i < PINS; i++)
   begin : g_pin
      logic want;
      logic val;
      // with alternate select the peripheral owns the direction bit
      assign want = alt_sel[i] ? alt_oe[i] : dir[i];
      assign val = alt_sel[i] ? alt_out[i] : data[i];
      always_comb
      begin
         // open drain only ever pulls low; no digital enable means no drive
         nxt_out[i] = open_drain[i] ? 1'b0 : val;
         nxt_oe_n[i] = ~(dig_en[i] & want & (~open_drain[i] | ~val));
         nxt_alt_in[i] = pad_sync[i] & dig_en[i];
      end
   end

   // pads start undriven
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_ff <= '0;
         oe_n_ff <= '1;
         alt_in_ff <= '0;
      end
      else
      begin
         out_ff <= nxt_out;
         oe_n_ff <= nxt_oe_n;
         alt_in_ff <= nxt_alt_in;
      end
   end

   assign pad_out = out_ff;
   assign pad_oe_n = oe_n_ff;
   assign alt_in = alt_in_ff;
endmodule : pad_drive_mux

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
module testbench;
   // bit 7 has no pad in this build, so reserved-bit behaviour is visible
   localparam logic [7:0] M = 8'h7F;
   // port C page, the one with four protected debug pins
   localparam logic [31:0] B = gpio_cfg_pkg::BASE_LOW + 32'h00002000;
   localparam logic [11:0] OFFS [11] = '{gpio_cfg_pkg::OFF_DIR, gpio_cfg_pkg::OFF_IRQ_SENSE,
      gpio_cfg_pkg::OFF_IRQ_BOTH, gpio_cfg_pkg::OFF_IRQ_EVENT, gpio_cfg_pkg::OFF_IRQ_MASK,
      gpio_cfg_pkg::OFF_DRV2, gpio_cfg_pkg::OFF_DRV4, gpio_cfg_pkg::OFF_DRV8,
      gpio_cfg_pkg::OFF_OPEN_DRAIN, gpio_cfg_pkg::OFF_PULL_DOWN, gpio_cfg_pkg::OFF_SLEW};
   // unaligned, unmapped, and a foreign port page
   localparam logic [31:0] BAD [3] = '{B + 32'h00000402, B + 32'h00000600,
      gpio_cfg_pkg::BASE_LOW + 32'h00000400};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic module_clk_en = 1'b0;
   logic [31:0] paddr = 32'h00000000;
   logic [31:0] pwdata = 32'h00000000;
   logic [7:0] pad_in = 8'h00;
   logic [7:0] alt_out = 8'h00;
   logic [7:0] alt_oe = 8'h00;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [7:0] pad_out, pad_oe_n, pad_pull_up, pad_pull_down, pad_digital_en;
   logic [7:0] pad_drive_2ma, pad_drive_4ma, pad_drive_8ma, pad_slew_limit, alt_in;
   int n_errors = 0;
   int check_count = 0;
   logic [31:0] rd;
   logic err;
   logic [31:0] w;
   logic [7:0] wv [11];

   gpio_port_cfg #(.PORT_INDEX(2), .PIN_MASK(M)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .module_clk_en(module_clk_en),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_up(pad_pull_up),
      .pad_pull_down(pad_pull_down), .pad_digital_en(pad_digital_en),
      .pad_drive_2ma(pad_drive_2ma), .pad_drive_4ma(pad_drive_4ma),
      .pad_drive_8ma(pad_drive_8ma), .pad_slew_limit(pad_slew_limit),
      .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in));

   // 200 MHz system clock
   always #2.5 pclk = ~pclk;

   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; answer taken at the edge where pready is seen high
   task apb(input logic wr_en, input logic [31:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [11:0] off, input logic [31:0] wd);
      apb(1'b1, B + 32'(off), wd);
   endtask : wr

   // expected word: pad-less positions read as zero, upper bits always zero
   function automatic logic [31:0] exp_word(input logic [7:0] e);
      exp_word = {24'h000000, e & M};
   endfunction : exp_word

   // read back and compare against the expected word
   task rc(input logic [11:0] off, input logic [7:0] e);
      apb(1'b0, B + 32'(off), 32'h00000000);
      chk(rd, exp_word(e));
   endtask : rc

   task finish_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   // watchdog: the tests need well under a thousand cycles
   initial
   begin
      #100000;
      n_errors++;
      finish_test();
   end

   // main sequence
   initial
   begin
      void'($urandom(49509));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({24'h0, pad_oe_n}, 32'h000000FF);
      chk({24'h0, pad_pull_down}, 32'h00000000);
      chk({24'h0, pad_pull_up & M}, 32'h0000000F);
      chk({24'h0, pad_digital_en & M}, 32'h0000000F);
      apb(1'b0, B + 32'h00000400, 32'h00000000);
      chk({31'h0, err}, 32'h00000001);
      module_clk_en <= 1'b1;
      apb(1'b0, B + 32'h00000400, 32'h00000000);
      chk({31'h0, err}, 32'h00000001);
      repeat (3) @(posedge pclk);
      rc(gpio_cfg_pkg::OFF_ALT_SEL, 8'h0F);
      rc(gpio_cfg_pkg::OFF_PULL_UP, 8'h0F);
      rc(gpio_cfg_pkg::OFF_DIG_EN, 8'h0F);
      rc(gpio_cfg_pkg::OFF_PULL_DOWN, 8'h00);
      rc(gpio_cfg_pkg::OFF_COMMIT, 8'hF0);
      $display("test reset values done");
      wr(gpio_cfg_pkg::OFF_COMMIT, 32'h000000FF);
      rc(gpio_cfg_pkg::OFF_COMMIT, 8'hF0);
      wr(gpio_cfg_pkg::OFF_ALT_SEL, 32'h00000000);
      rc(gpio_cfg_pkg::OFF_ALT_SEL, 8'h0F);
      wr(gpio_cfg_pkg::OFF_UNLOCK, gpio_cfg_pkg::UNLOCK_KEY);
      wr(gpio_cfg_pkg::OFF_COMMIT, 32'h00000005);
      rc(gpio_cfg_pkg::OFF_COMMIT, 8'hF5);
      wr(gpio_cfg_pkg::OFF_ALT_SEL, 32'h000000F0);
      rc(gpio_cfg_pkg::OFF_ALT_SEL, 8'h7A);
      wr(gpio_cfg_pkg::OFF_COMMIT, 32'h0000000F);
      wr(gpio_cfg_pkg::OFF_ALT_SEL, 32'h00000000);
      rc(gpio_cfg_pkg::OFF_ALT_SEL, 8'h00);
      wr(gpio_cfg_pkg::OFF_UNLOCK, 32'h00000000);
      $display("test commit protection done");
      // random values through the plain registers except pull-up and digital enable
      for (int i = 0; i < 11; i++)
      begin
         w = $urandom;
         wv[i] = w[7:0];
         wr(OFFS[i], w);
         rc(OFFS[i], w[7:0]);
      end
      chk({24'h0, pad_slew_limit & M}, {24'h0, w[7:0] & M});
      chk({24'h0, pad_drive_2ma & M}, exp_word(wv[5]));
      chk({24'h0, pad_drive_4ma & M}, exp_word(wv[6]));
      chk({24'h0, pad_drive_8ma & M}, exp_word(wv[7]));
      chk({24'h0, pad_pull_down & M}, exp_word(wv[9]));
      wr(gpio_cfg_pkg::OFF_IRQ_SENSE, 32'h00000000);
      wr(gpio_cfg_pkg::OFF_IRQ_BOTH, 32'h00000000);
      wr(gpio_cfg_pkg::OFF_IRQ_EVENT, 32'h00000004);
      wr(gpio_cfg_pkg::OFF_IRQ_MASK, 32'h00000004);
      rc(gpio_cfg_pkg::OFF_IRQ_EVENT, 8'h04);
      rc(gpio_cfg_pkg::OFF_IRQ_MASK, 8'h04);
      $display("test random registers done");
      // low nibble drives, upper pins capture the pad
      pad_in <= 8'($urandom);
      alt_out <= 8'($urandom);
      alt_oe <= 8'($urandom);
      wr(gpio_cfg_pkg::OFF_OPEN_DRAIN, 32'h00000000);
      wr(gpio_cfg_pkg::OFF_DIG_EN, 32'h000000FF);
      wr(gpio_cfg_pkg::OFF_DIR, 32'h0000000F);
      wr(gpio_cfg_pkg::OFF_DATA_TOP, 32'h00000005);
      repeat (2) @(posedge pclk);
      chk({28'h0, pad_out[3:0]}, 32'h00000005);
      chk({24'h0, pad_oe_n & M}, 32'h00000070);
      repeat (4) @(posedge pclk);
      rc(gpio_cfg_pkg::OFF_DATA_TOP, (pad_in & 8'h70) | 8'h05);
      // pin 4 as timer capture, pin 5 as timer output; open drain already 0
      wr(gpio_cfg_pkg::OFF_ALT_SEL, 32'h00000030);
      repeat (2) @(posedge pclk);
      chk({31'h0, pad_out[5]}, {31'h0, alt_out[5]});
      chk({31'h0, pad_oe_n[5]}, {31'h0, ~alt_oe[5]});
      chk({24'h0, alt_in}, exp_word(pad_in));
      $display("test direction done");
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b0, BAD[i], 32'h00000000);
         chk({31'h0, err}, 32'h00000001);
         chk(rd, 32'h00000000);
      end
      $display("test address decode done");
      finish_test();
   end
endmodule : testbench
